// ===== rtl/dtm_pkg.sv
// Package with register map, field layout and timing constants of the dual timer.
package dtm_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL_U   = 5'h00;
  localparam logic [4:0] OFS_CCTL_U   = 5'h04;
  localparam logic [4:0] OFS_STAT_U   = 5'h08;
  localparam logic [4:0] OFS_CNT_U    = 5'h0C;
  localparam logic [4:0] OFS_CMPA_U   = 5'h10;
  localparam logic [4:0] OFS_CMPB_U   = 5'h14;
  localparam logic [4:0] CH_STRIDE    = 5'h18;
  localparam int         NUM_REGS_CH  = 6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_COMPARE_B_IRQ_ENABLE  = 7;
  localparam int POS_COMPARE_A_IRQ_ENABLE  = 6;
  localparam int POS_WRAP_IRQ_ENABLE   = 5;
  localparam int POS_CCLR   = 3;
  localparam int POS_CKS    = 0;
  localparam int POS_RISLVL = 3;
  localparam int POS_PRE    = 0;
  localparam int POS_FLGB   = 7;
  localparam int POS_FLGA   = 6;
  localparam int POS_FLGO   = 5;
  localparam int POS_CONVERSION_TRIGGER_ENABLE   = 4;
  localparam int POS_OSB    = 2;
  localparam int POS_OSA    = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_CCTL  = 8'h00;
  localparam logic [7:0] RST_CMP   = 8'hFF;
  localparam logic [7:0] RST_CNT   = 8'h00;

  // ----------------------------------------------------------------
  // Clock select codes and divider taps
  // ----------------------------------------------------------------
  localparam logic [2:0] CKS_OFF   = 3'h0;
  localparam logic [2:0] CKS_DIV1  = 3'h1;
  localparam logic [2:0] CKS_DIV2  = 3'h2;
  localparam logic [2:0] CKS_DIV3  = 3'h3;
  localparam logic [2:0] CKS_CASC  = 3'h4;
  localparam logic [2:0] CKS_EXTR  = 3'h5;
  localparam logic [2:0] CKS_EXTF  = 3'h6;
  localparam logic [2:0] CKS_EXTB  = 3'h7;
  localparam int TAP_D2    = 0;
  localparam int TAP_D8    = 2;
  localparam int TAP_D32   = 4;
  localparam int TAP_D64   = 5;
  localparam int TAP_D1024 = 9;
  localparam int TAP_D8192 = 12;
  localparam int PRE_W     = 13;
  localparam logic       UNIT_HAS_EXT = 1'b1;

  typedef enum logic [1:0] {DTM_OS_KEEP, DTM_OS_LOW, DTM_OS_HIGH, DTM_OS_TOGGLE} dtm_os_e;

  // Events of one channel in one cycle.
  typedef struct packed
  {
    logic match_a;
    logic match_b;
    logic wrap;
  } dtm_evt_s;

endpackage

// ===== rtl/dtm_chan.sv
// One 8-bit timer channel: counter, compares, flags and output pin logic.
`timescale 1ns/1ps
module dtm_chan
  import dtm_pkg::*;
#(
  parameter logic IS_UPPER = 1'b1
)
(
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Count control.
  input  wire logic       count_en,
  input  wire logic       ext_clr,
  // Register write port.
  input  wire logic [2:0] wr_sel,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       flag_rd,
  // Transfer controller start clears.
  input  wire logic       xfer_clr_a,
  input  wire logic       xfer_clr_b,
  // State out.
  output logic [7:0]      timer_control,
  output logic [7:0]      counter_control,
  output logic [7:0]      status_rd,
  output logic [7:0]      up_counter,
  output logic [7:0]      compare_a_constant,
  output logic [7:0]      compare_b_constant,
  output dtm_evt_s        evt,
  output logic            timer_output_pin,
  output logic            pin_oe_n
);

  logic [2:0] flags;
  logic [2:0] flag_armed;
  logic       conversion_trigger_enable;
  logic [1:0] os_a;
  logic [1:0] os_b;
  logic       hit_a;
  logic       hit_b;
  logic       wrap;
  logic       clr_now;
  logic [2:0] wr_zero;
  logic [1:0] hit_q;
  logic [3:0] os_bits;

  // Compare suspended while software writes the constant.
  assign hit_a = (up_counter == compare_a_constant) && !(wr_en && wr_sel == 3'd4); // R10 R22
  assign hit_b = (up_counter == compare_b_constant) && !(wr_en && wr_sel == 3'd5); // R09 R22
  assign wrap  = count_en && (up_counter == 8'hFF);                                // R11
  assign evt   = '{match_a: hit_a & ~hit_q[0], match_b: hit_b & ~hit_q[1], wrap: wrap};
  assign os_a  = os_bits[POS_OSA+1:POS_OSA];
  assign os_b  = os_bits[POS_OSB+1:POS_OSB];

  // Matches act once on entry, as the compare stays equal for a whole count period.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      hit_q <= 2'b00;
    else
      hit_q <= {hit_b, hit_a};
  end

  // Clear source chosen by the clear field.
  always_comb
  begin
    case (timer_control[POS_CCLR+1:POS_CCLR])
      2'd1:    clr_now = hit_a;
      2'd2:    clr_now = hit_b;
      2'd3:    clr_now = ext_clr;
      default: clr_now = 1'b0;
    endcase // R23
  end

  // Control registers.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      timer_control             <= RST_CTRL;
      counter_control           <= RST_CCTL;
      compare_a_constant        <= RST_CMP;
      compare_b_constant        <= RST_CMP;
      conversion_trigger_enable <= 1'b0;
      os_bits                   <= 4'h0;
    end
    else if (wr_en)
    begin
      case (wr_sel)
        3'd0: timer_control   <= wr_data;
        3'd1: counter_control <= {4'h0, wr_data[3], 1'b0, wr_data[1:0]};
        3'd2:
        begin
          os_bits <= wr_data[3:0];
          if (IS_UPPER)
            conversion_trigger_enable <= wr_data[POS_CONVERSION_TRIGGER_ENABLE]; // R15
        end
        3'd4: compare_a_constant <= wr_data;
        3'd5: compare_b_constant <= wr_data;
        default: ;
      endcase
    end
  end

  // Counter; clear has priority over counting.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      up_counter <= RST_CNT;
    else if (wr_en && wr_sel == 3'd3)
      up_counter <= wr_data;
    else if (clr_now)
      up_counter <= RST_CNT;
    else if (count_en)
      up_counter <= up_counter + 8'h01;
  end

  // Flags: a read while set arms the clear; a written 0 or a transfer clear clears; a set wins.
  assign wr_zero = {~wr_data[POS_FLGB], ~wr_data[POS_FLGA], ~wr_data[POS_FLGO]};
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      flags      <= 3'b000;
      flag_armed <= 3'b000;
    end
    else
    begin
      if (flag_rd)
        flag_armed <= flag_armed | flags; // R12
      for (int i = 0; i < 3; i++)
      begin
        if (wr_en && wr_sel == 3'd2 && flag_armed[i] && wr_zero[i])
        begin
          flags[i]      <= 1'b0; // R12 R14
          flag_armed[i] <= 1'b0;
        end
      end
      if (xfer_clr_b)
        flags[2] <= 1'b0; // R13
      if (xfer_clr_a)
        flags[1] <= 1'b0; // R13
      if (hit_b)
        flags[2] <= 1'b1; // R09
      if (hit_a)
        flags[1] <= 1'b1; // R10
      if (wrap)
        flags[0] <= 1'b1; // R11
    end
  end

  assign status_rd = {flags, IS_UPPER ? conversion_trigger_enable : 1'b1, os_bits}; // R16

  // Output pin: A alone acts when both match and its code is not keep; zero codes release the pin.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      timer_output_pin <= 1'b0; // R20
      pin_oe_n         <= 1'b1;
    end
    else
    begin
      pin_oe_n <= (os_bits == 4'h0); // R19
      if (evt.match_a && os_a != DTM_OS_KEEP)
        timer_output_pin <= (os_a == DTM_OS_TOGGLE) ? ~timer_output_pin : os_a[1]; // R18
      else if (evt.match_b && os_b != DTM_OS_KEEP)
        timer_output_pin <= (os_b == DTM_OS_TOGGLE) ? ~timer_output_pin : os_b[1]; // R17
    end
  end

endmodule

// ===== rtl/dtm_top.sv
// Dual cascadable 8-bit timer with Avalon-MM register slave.
//
// Behaviour
// R01 - Prescale field with clock select chooses divided rate and count edge.
// R02 - Code one counts at clock/8 or clock/2, prescale high picks edge.
// R03 - Code two counts at clock/64 or clock/32, chosen edge.
// R04 - Code three counts at clock/8192 or clock/1024, chosen edge.
// R05 - Upper channel in cascade counts lower channel overflows.
// R06 - Lower channel in cascade counts upper channel compare A matches.
// R07 - Software never cascades both channels; then neither counts.
// R08 - Upper three codes count external clock rising, falling or both.
// R09 - Compare flag B sets when counter equals compare B constant.
// R10 - Compare flag A sets when counter equals compare A constant.
// R11 - Overflow flag sets when counter wraps from FF to 00.
// R12 - A flag clears only on written 0 after reading it as 1; compare flags here also clear on a transfer start (R13).
// R13 - Compare flag clears when its transfer starts with disable select 0.
// R14 - Writing 1 to a flag never sets it.
// R15 - Upper channel bit 4 gates conversion start on compare A.
// R16 - Lower channel bit 4 reads 1 and ignores writes.
// R17 - Output select B: keep, drive 0, drive 1, toggle on match B.
// R18 - Output select A: same four actions on match A.
// R19 - All four output select bits zero: pin not driven.
// R20 - After reset output is 0 until first compare match.
// R21 - Interrupt code rereads the flag after writing 0.
// R22 - Comparison suspended in a cycle writing that compare constant.
// R23 - Clear field: none, match A, match B, external reset edge or level.
// R24 - Enable bits gate compare B, compare A and overflow requests.
// R25 - Selected edges become single-cycle count enables in the system clock.
`timescale 1ns/1ps
module dtm_top
  import dtm_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Avalon-MM slave.
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // External count clock and counter reset inputs.
  input  wire logic        ext_count_clk,
  input  wire logic        ext_reset_in,
  // Transfer controller start acknowledges, per channel {b,a}.
  input  wire logic [1:0]  xfer_start_upper,
  input  wire logic [1:0]  xfer_start_lower,
  input  wire logic [1:0]  disable_on_completion_select_upper,
  input  wire logic [1:0]  disable_on_completion_select_lower,
  // Interrupt requests and conversion trigger.
  output logic [2:0]       irq_upper,
  output logic [2:0]       irq_lower,
  output logic             conversion_start,
  // Timer output pins.
  output logic [1:0]       timer_output_pin,
  output logic [1:0]       timer_output_oe_n
);

  // ----------------------------------------------------------------
  // Prescaler and edge detection
  // ----------------------------------------------------------------
  logic [PRE_W-1:0] prescaler;
  logic [PRE_W-1:0] prescaler_q;
  logic             ext_q;
  logic             ext_rst_q;
  logic [1:0]       count_en;
  logic [7:0]       tctrl [2];
  logic [7:0]       cctrl [2];
  logic [7:0]       stat  [2];
  logic [7:0]       cnt   [2];
  logic [7:0]       cmpa  [2];
  logic [7:0]       cmpb  [2];
  dtm_evt_s         evt   [2];
  logic [1:0]       pin_raw;
  logic [1:0]       pin_oe_raw;

  // Free-running divider; its bits are the divided clocks.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      prescaler   <= '0;
      prescaler_q <= '0;
    end
    else
    begin
      prescaler   <= prescaler + 13'h0001;
      prescaler_q <= prescaler;
    end
  end

  // Previous samples of the external inputs, for edge detection.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ext_q     <= 1'b0;
      ext_rst_q <= 1'b0;
    end
    else
    begin
      ext_q     <= ext_count_clk;
      ext_rst_q <= ext_reset_in;
    end
  end

  // ----------------------------------------------------------------
  // Count enable per channel (index 0 upper, 1 lower)
  // ----------------------------------------------------------------
  logic [1:0] ext_clr;
  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_ce
      logic [2:0] cks;
      logic [1:0] pre;
      logic       tap_now;
      logic       tap_old;
      logic       cas_both;
      int         tap_i;
      assign cks = tctrl[c][POS_CKS+2:POS_CKS];
      assign pre = cctrl[c][POS_PRE+1:POS_PRE];
      assign cas_both = (tctrl[0][2:0] == CKS_CASC) && (tctrl[1][2:0] == CKS_CASC);
      // Select the tap; the prescale low bit picks the faster rate.
      always_comb
      begin
        case (cks)
          CKS_DIV1: tap_i = pre[0] ? TAP_D2 : TAP_D8;       // R02
          CKS_DIV2: tap_i = pre[0] ? TAP_D32 : TAP_D64;     // R03
          CKS_DIV3: tap_i = pre[0] ? TAP_D1024 : TAP_D8192; // R04
          default:  tap_i = TAP_D2;
        endcase
      end
      assign tap_now = prescaler[tap_i];
      assign tap_old = prescaler_q[tap_i];
      // One-cycle enable on the selected edge of the chosen source.
      always_comb
      begin
        case (cks)
          CKS_DIV1, CKS_DIV2, CKS_DIV3:
            count_en[c] = pre[1] ? (tap_old & ~tap_now) : (~tap_old & tap_now); // R01 R25
          CKS_CASC:
            count_en[c] = cas_both ? 1'b0 :                                     // R07
                          (c == 0) ? evt[1].wrap : evt[0].match_a;              // R05 R06
          CKS_EXTR: count_en[c] = UNIT_HAS_EXT & ~ext_q & ext_count_clk;        // R08
          CKS_EXTF: count_en[c] = UNIT_HAS_EXT & ext_q & ~ext_count_clk;        // R08
          CKS_EXTB: count_en[c] = UNIT_HAS_EXT & (ext_q ^ ext_count_clk);       // R08
          default:  count_en[c] = 1'b0;
        endcase
      end
      // External counter reset by rising edge or high level.
      assign ext_clr[c] = cctrl[c][POS_RISLVL] ? ext_reset_in
                                               : (ext_reset_in & ~ext_rst_q); // R23
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus slave: one wait state, answer on second cycle
  // ----------------------------------------------------------------
  logic       busy;
  logic [1:0] wr_en;
  logic [1:0] rd_flag;
  logic [2:0] sel;
  logic       ch;
  logic       hit;
  logic [5:0] rel;

  assign ch  = (address >= CH_STRIDE[5:0]);
  assign rel = ch ? address - 6'(CH_STRIDE) : address;
  assign sel = rel[4:2];
  assign hit = (address[1:0] == 2'b00) && (rel[4:2] < 3'(NUM_REGS_CH))
               && (address < 6'(2 * CH_STRIDE));

  // Wait on the first cycle, drop waitrequest and accept on the second.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      waitrequest <= 1'b1;
    else
      waitrequest <= !((read || write) && waitrequest);
  end
  assign busy = !waitrequest;

  // Write strobe to the addressed channel, on the accepting edge only.
  always_comb
  begin
    wr_en   = 2'b00;
    rd_flag = 2'b00;
    if (busy && hit && write && byteenable[0])
      wr_en[ch] = 1'b1;
    if (busy && hit && read && sel == 3'd2)
      rd_flag[ch] = 1'b1; // R12
  end

  // Read data registered; unmapped addresses read zero.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      readdata <= 32'h0000_0000;
    else if (read && !busy)
    begin
      readdata <= 32'h0000_0000;
      if (hit)
      begin
        case (sel)
          3'd0:    readdata[7:0] <= tctrl[ch];
          3'd1:    readdata[7:0] <= cctrl[ch];
          3'd2:    readdata[7:0] <= stat[ch];
          3'd3:    readdata[7:0] <= cnt[ch];
          3'd4:    readdata[7:0] <= cmpa[ch];
          default: readdata[7:0] <= cmpb[ch];
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
      logic [1:0] xs;
      logic [1:0] ds;
      assign xs = (c == 0) ? xfer_start_upper : xfer_start_lower;
      assign ds = (c == 0) ? disable_on_completion_select_upper
                           : disable_on_completion_select_lower;
      dtm_chan #(.IS_UPPER(c == 0)) u_chan (
        .clk_sys            (clk_sys),
        .rstn               (rstn),
        .count_en           (count_en[c]),
        .ext_clr            (ext_clr[c]),
        .wr_sel             (sel),
        .wr_en              (wr_en[c]),
        .wr_data            (writedata[7:0]),
        .flag_rd            (rd_flag[c]),
        .xfer_clr_a         (xs[0] & ~ds[0]), // R13
        .xfer_clr_b         (xs[1] & ~ds[1]), // R13
        .timer_control      (tctrl[c]),
        .counter_control    (cctrl[c]),
        .status_rd          (stat[c]),
        .up_counter         (cnt[c]),
        .compare_a_constant (cmpa[c]),
        .compare_b_constant (cmpb[c]),
        .evt                (evt[c]),
        .timer_output_pin   (pin_raw[c]),
        .pin_oe_n           (pin_oe_raw[c])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Requests and outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      irq_upper         <= 3'b000;
      irq_lower         <= 3'b000;
      conversion_start  <= 1'b0;
      timer_output_pin  <= 2'b00;
      timer_output_oe_n <= 2'b11;
    end
    else
    begin
      irq_upper        <= stat[0][7:5] & tctrl[0][7:5]; // R24
      irq_lower        <= stat[1][7:5] & tctrl[1][7:5]; // R24
      conversion_start <= evt[0].match_a & stat[0][POS_CONVERSION_TRIGGER_ENABLE]; // R15
      timer_output_pin  <= pin_raw;
      timer_output_oe_n <= pin_oe_raw;
    end
  end

endmodule

// ===== test/dtm_top_sva.sv
// Concurrent checks on the bus timing and outputs of the dual timer.
`timescale 1ns/1ps
module dtm_top_sva
  import dtm_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        rstn,
  // Register bus.
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Outputs.
  input wire logic [2:0]  irq_upper,
  input wire logic        conversion_start,
  input wire logic [1:0]  timer_output_pin,
  input wire logic [1:0]  timer_output_oe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // ----------------
  // Bus steps
  // ----------------
  // A request is new when idle one cycle earlier.
  sequence s_new_req;
    (read || write) && !$past(read || write);
  endsequence
  sequence s_take;
    !waitrequest && (read || write);
  endsequence

  // Accepted writes to the upper control and status words.
  wire wr_ok   = write && !waitrequest && byteenable[0];
  wire wr_stat = wr_ok && address == 6'(OFS_STAT_U);
  wire wr_ctrl = wr_ok && address == 6'(OFS_CTRL_U);

  // ----------------
  // Assertions
  // ----------------
  chk_one_wait: assert property (s_new_req |-> waitrequest ##1 s_take)
    else $error("late accept");
  chk_wait_short: assert property (!waitrequest |-> (read || write) ##1 waitrequest)
    else $error("long accept");
  chk_rd_narrow: assert property (s_take and read |-> readdata[31:8] == 24'h00_0000)
    else $error("readdata high bits set");
  chk_low_bit4: assert property (
    read && !waitrequest && address == 6'(OFS_STAT_U + CH_STRIDE) |-> readdata[POS_CONVERSION_TRIGGER_ENABLE])
    else $error("lower bit 4 zero");
  chk_reset_out: assert property (
    $rose(rstn) |-> timer_output_pin == 2'b00 && timer_output_oe_n == 2'b11)
    else $error("pins after reset");
  chk_pin_off: assert property (wr_stat && writedata[3:0] == 4'h0 |-> ##3 timer_output_oe_n[0])
    else $error("pin driven while off");
  chk_pin_on: assert property (wr_stat && writedata[3:0] != 4'h0 |=> ##2 !timer_output_oe_n[0])
    else $error("pin not driven");
  chk_irq_mask: assert property (wr_ctrl && writedata[7:5] == 3'b000 |-> ##2 irq_upper == 3'b000)
    else $error("request not masked");
  chk_adc_gate: assert property (wr_stat && !writedata[POS_CONVERSION_TRIGGER_ENABLE] |-> ##2 !conversion_start)
    else $error("conversion not gated");
endmodule

bind dtm_top dtm_top_sva chk
(
  .clk_sys (clk_sys),
  .rstn (rstn),
  .address (address),
  .read (read),
  .write (write),
  .writedata (writedata),
  .byteenable (byteenable),
  .readdata (readdata),
  .waitrequest (waitrequest),
  .irq_upper (irq_upper),
  .conversion_start (conversion_start),
  .timer_output_pin (timer_output_pin),
  .timer_output_oe_n (timer_output_oe_n)
);

// ===== test/dtm_top_bench.sv
// Self-checking bench for the dual cascadable timer.
`timescale 1ns/1ps
module dtm_top_bench
  import dtm_pkg::*;
;
  // Register addresses of the upper channel; the lower adds lo.
  localparam logic [5:0] ctl = 6'(OFS_CTRL_U);
  localparam logic [5:0] cct = 6'(OFS_CCTL_U);
  localparam logic [5:0] sta = 6'(OFS_STAT_U);
  localparam logic [5:0] cnt = 6'(OFS_CNT_U);
  localparam logic [5:0] cpa = 6'(OFS_CMPA_U);
  localparam logic [5:0] cpb = 6'(OFS_CMPB_U);
  localparam logic [5:0] lo  = 6'(CH_STRIDE);
  localparam int         div [6] = '{8, 2, 64, 32, 8192, 1024};
  localparam int         ks  [6] = '{32, 32, 32, 32, 2, 8};

  logic        clk_sys       = 1'b0;
  logic        rstn          = 1'b0;
  logic [5:0]  address       = 6'h00;
  logic        read          = 1'b0;
  logic        write         = 1'b0;
  logic [31:0] writedata     = 32'h0000_0000;
  logic [3:0]  byteenable    = 4'h1;
  logic        ext_count_clk = 1'b0;
  logic [1:0]  xfer_up       = 2'b00;
  logic [1:0]  dis_sel_up    = 2'b00;
  logic        conv_seen     = 1'b0;
  logic [7:0]  rd;
  logic [1:0]  a;
  logic [1:0]  b;
  logic        p;
  wire  [31:0] readdata;
  wire         waitrequest;
  wire  [2:0]  irq_upper;
  wire         conversion_start;
  wire  [1:0]  timer_output_pin;
  wire  [1:0]  timer_output_oe_n;
  int          errors        = 0;
  int          total_checks  = 0;
  int          cycles        = 0;
  int          seed          = 60;

  // Clock at 10 MHz.
  always #50 clk_sys = ~clk_sys;

  dtm_top dut
  (
    .clk_sys (clk_sys),
    .rstn (rstn),
    .address (address),
    .read (read),
    .write (write),
    .writedata (writedata),
    .byteenable (byteenable),
    .readdata (readdata),
    .waitrequest (waitrequest),
    .ext_count_clk (ext_count_clk),
    .ext_reset_in (1'b0),
    .xfer_start_upper (xfer_up),
    .xfer_start_lower (2'b00),
    .disable_on_completion_select_upper (dis_sel_up),
    .disable_on_completion_select_lower (2'b00),
    .irq_upper (irq_upper),
    .irq_lower (),
    .conversion_start (conversion_start),
    .timer_output_pin (timer_output_pin),
    .timer_output_oe_n (timer_output_oe_n)
  );

  // Watchdog sized by the longest prescale window.
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (conversion_start === 1'b1)
      conv_seen <= 1'b1;
    if (cycles == 60000)
    begin
      errors = errors + 1;
      tally_and_finish();
    end
  end

  // ----------------
  // Helpers
  // ----------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus transfer, then one idle edge.
  task automatic bus(input logic wr, input logic [5:0] adr, input logic [7:0] d);
    address   <= adr;
    write     <= wr;
    read      <= !wr;
    writedata <= 32'(d);
    @(posedge clk_sys);
    while (waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = readdata[7:0];
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rchk(input string what, input logic [5:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00);
    check(what, rd, exp);
  endtask

  // Pin level after one compare action.
  function automatic logic os_next(input logic [1:0] c, input logic lvl);
    return c == 2'b00 ? lvl : (c == 2'b11 ? !lvl : c[1]);
  endfunction

  // Divider phase is free, so a count within two is exact.
  function automatic logic [7:0] near(input logic [7:0] got, input int k);
    return (int'(got) >= k - 2 && int'(got) <= k + 2) ? 8'(k) : got;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    check("reset pins", {timer_output_pin, timer_output_oe_n}, 4'b0011);
    for (int c = 0; c < 2; c++)
    begin
      automatic logic [5:0] o = c ? lo : 6'h00;
      rchk("control", ctl + o, RST_CTRL);
      rchk("counter control", cct + o, RST_CCTL);
      rchk("counter", cnt + o, RST_CNT);
      rchk("compare a", cpa + o, RST_CMP);
      rchk("compare b", cpb + o, RST_CMP);
      rchk("status", sta + o, c ? 8'h10 : 8'h00);
    end
    rchk("unmapped", 6'h30, 8'h00);
    rchk("misaligned", 6'h01, 8'h00);
    bus(1'b1, sta, 8'hE0);
    rchk("ones ignored", sta, 8'h00);
    bus(1'b1, sta + lo, 8'h00);
    rchk("lower bit 4", sta + lo, 8'h10);
    $display("done: reset and access");
    // Every internal rate, with a random counting edge.
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, ctl, 8'(i / 2 + 1));
      bus(1'b1, cct, {6'h00, 1'($random(seed)), 1'(i % 2)});
      bus(1'b1, cnt, 8'h00);
      repeat (div[i] * ks[i]) @(posedge clk_sys);
      bus(1'b0, cnt, 8'h00);
      check("prescaled count", near(rd, ks[i]), 8'(ks[i]));
    end
    $display("done: prescaler");
    // Upper counts lower wraps; a write without a read keeps flags.
    bus(1'b1, ctl, {5'h00, CKS_CASC});
    bus(1'b1, cnt, 8'h00);
    bus(1'b1, cct + lo, 8'h01);
    bus(1'b1, cnt + lo, 8'hFE);
    bus(1'b1, ctl + lo, {5'h00, CKS_DIV1});
    repeat (20) @(posedge clk_sys);
    bus(1'b1, sta + lo, 8'h00);
    rchk("cascade upper", cnt, 8'h01);
    rchk("lower flags kept", sta + lo, 8'hF0);
    bus(1'b1, sta + lo, 8'h00);
    rchk("lower flags cleared", sta + lo, 8'h10);
    // Both channels in cascade must stay frozen.
    bus(1'b1, ctl + lo, {5'h00, CKS_CASC});
    bus(1'b1, cnt, 8'hFF);
    bus(1'b1, cnt + lo, 8'hFF);
    repeat (50) @(posedge clk_sys);
    rchk("frozen upper", cnt, 8'hFF);
    rchk("frozen lower", cnt + lo, 8'hFF);
    // Lower counts upper compare A; conversion start enabled.
    bus(1'b1, cnt + lo, 8'h00);
    bus(1'b1, cpa, 8'h10);
    bus(1'b1, sta, 8'h10);
    bus(1'b1, cnt, 8'h00);
    bus(1'b1, cct, 8'h01);
    bus(1'b1, ctl, {5'h00, CKS_DIV1});
    repeat (40) @(posedge clk_sys);
    rchk("match count", cnt + lo, 8'h01);
    check("conversion start", conv_seen, 1'b1);
    bus(1'b1, ctl + lo, 8'h00);
    $display("done: cascade");
    // Every output code on both matches, then random pairs.
    bus(1'b1, cpa, 8'h04);
    bus(1'b1, cpb, 8'h08);
    p = 1'b0;
    for (int t = 0; t < 6; t++)
    begin
      a = t < 4 ? 2'(t) : 2'($random(seed));
      b = t < 4 ? 2'(3 - t) : 2'($random(seed));
      bus(1'b1, ctl, 8'hC0);
      bus(1'b1, sta, {4'h0, b, a});
      bus(1'b1, cnt, 8'h00);
      bus(1'b1, ctl, 8'hC1);
      repeat (30) @(posedge clk_sys);
      bus(1'b1, ctl, 8'hC0);
      repeat (2) @(posedge clk_sys);
      p = os_next(b, os_next(a, p));
      check("level", timer_output_pin[0], p);
      check("oe", timer_output_oe_n[0], a == 2'b00 && b == 2'b00);
      check("irq on", irq_upper, 3'b110);
    end
    // Transfer start clears A, whose disable select is zero.
    dis_sel_up <= 2'b10;
    xfer_up    <= 2'b11;
    @(posedge clk_sys);
    xfer_up <= 2'b00;
    rchk("transfer clear", sta, {4'b1000, b, a});
    bus(1'b1, ctl, 8'h20);
    repeat (2) @(posedge clk_sys);
    check("irq off", irq_upper, 3'b000);
    $display("done: outputs and requests");
    // External clock on each edge choice.
    for (int e = 0; e < 3; e++)
    begin
      bus(1'b1, cnt, 8'h00);
      bus(1'b1, ctl, 8'(5 + e));
      repeat (4)
      begin
        repeat (3) @(posedge clk_sys);
        ext_count_clk <= 1'b1;
        repeat (3) @(posedge clk_sys);
        ext_count_clk <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      bus(1'b1, ctl, 8'h00);
      rchk("external count", cnt, e == 2 ? 8'h08 : 8'h04);
    end
    $display("done: external clock");
    tally_and_finish();
  end
endmodule
